// file: hdl/ncs_sequencer.sv
// Purpose: command sequencer of the nonvolatile_ctrl_unit
// Assumes: ref_clk 25 MHz, srst synchronous active high, AXI4-Lite slave
// Notes: array timing is owned by the memory side via memDone
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`include "ncs_defines.svh"

module ncs_sequencer (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debugAccess,
  input wire logic keyWritten,
  input wire logic instrRetired,
  input wire logic pbStoreValid,
  input wire logic [15:0] pbStoreAddr,
  input wire logic [7:0] pbStoreData,
  input wire logic keepEepromOnWipe,
  input wire logic sleepActive,
  input wire logic sleepIsIdle,
  input wire logic wakeUp,
  input wire logic memDone,
  output logic cpuStall,
  output logic memStart,
  output ncs_pkg::ncs_cmd_t memOp,
  output logic memTargetEeprom,
  output logic memWipeEeprom,
  output logic [15:0] memAddr,
  output logic [255:0] memData,
  output logic [31:0] memByteMask,
  output logic irqReq,
  output logic wakeReq,
  output logic nvmAsleep,
  output logic clockHold
);
  import ncs_pkg::*;

  ncs_state_t state;
  ncs_cmd_t cmdReg;
  ncs_cmd_t reqCmd;
  logic awHeld, wHeld, wFromDebug, doWrite;
  logic [7:0] wAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic [31:0] rdNext;
  logic rdHit;
  logic [1:0] lockReg;
  logic intEnReg, irqFlagReg, faultReg, flBusy, eeprom_active;
  logic [15:0] fuseDataReg, targetAddr;
  logic [2:0] unlockCnt, clearCnt;
  logic unlocked, cmdTry, toEe, startOk, eeDone, pbClearNow;
  logic [7:0] pbuf [`NCS_PAGE_BYTES];
  logic [31:0] pbMark;
  logic [`NCS_PB_AW-1:0] pbIdx, pbIdxLast;
  logic pbWrote;
  logic [7:0] pbExpect;

  function automatic logic isReg(input logic [7:0] a, input logic [5:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b0;
      wAddrReg <= 8'h00;
      wFromDebug <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awHeld <= 1'b1;
      wAddrReg <= s_axi_awaddr;
      wFromDebug <= debugAccess;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end else if (!awHeld && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b0;
      wDataReg <= 32'h0000_0000;
      wStrbReg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wHeld <= 1'b1;
      wDataReg <= s_axi_wdata;
      wStrbReg <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end else if (!wHeld && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NCS_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (isReg(wAddrReg, `NCS_IDX_CMD) || isReg(wAddrReg, `NCS_IDX_LOCK) ||
        isReg(wAddrReg, `NCS_IDX_STATUS) || isReg(wAddrReg, `NCS_IDX_IRQ_ENABLE_ALIAS) ||
        isReg(wAddrReg, `NCS_IDX_FLAGS) || isReg(wAddrReg, `NCS_IDX_DATA) ||
        isReg(wAddrReg, `NCS_IDX_ADDR)) ? `NCS_RESP_OKAY : `NCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------
  always_comb begin
    rdNext = 32'h0000_0000;
    rdHit = 1'b1;
    if (isReg(s_axi_araddr, `NCS_IDX_CMD)) begin
      rdNext[2:0] = cmdReg;
    end else if (isReg(s_axi_araddr, `NCS_IDX_LOCK)) begin
      rdNext[1:0] = lockReg;
    end else if (isReg(s_axi_araddr, `NCS_IDX_STATUS)) begin
      rdNext[`NCS_ST_FAULT] = faultReg;
      rdNext[`NCS_ST_EE] = eeprom_active;
      rdNext[`NCS_ST_FL] = flBusy;
    end else if (isReg(s_axi_araddr, `NCS_IDX_IRQ_ENABLE_ALIAS)) begin
      rdNext[`NCS_INT_BIT] = intEnReg;
    end else if (isReg(s_axi_araddr, `NCS_IDX_FLAGS)) begin
      rdNext[`NCS_INT_BIT] = irqFlagReg;
    end else if (isReg(s_axi_araddr, `NCS_IDX_DATA)) begin
      rdNext[15:0] = fuseDataReg;
    end else if (isReg(s_axi_araddr, `NCS_IDX_ADDR)) begin
      rdNext[15:0] = targetAddr;
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `NCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdNext;
      s_axi_rresp <= rdHit ? `NCS_RESP_OKAY : `NCS_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Plain registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lockReg <= 2'h0;
      intEnReg <= 1'b0;
      fuseDataReg <= 16'h0000;
    end else if (doWrite) begin
      // Lock bits only set; only reset clears them
      if (isReg(wAddrReg, `NCS_IDX_LOCK) && wStrbReg[0]) begin
        lockReg <= lockReg | wDataReg[1:0];
      end
      if (isReg(wAddrReg, `NCS_IDX_IRQ_ENABLE_ALIAS) && wStrbReg[0]) begin
        intEnReg <= wDataReg[`NCS_INT_BIT];
      end
      if (isReg(wAddrReg, `NCS_IDX_DATA)) begin
        if (wStrbReg[0]) begin
          fuseDataReg[7:0] <= wDataReg[7:0];
        end
        if (wStrbReg[1]) begin
          fuseDataReg[15:8] <= wDataReg[15:8];
        end
      end
    end
  end

  // Last buffer store also points the target page
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      targetAddr <= 16'h0000;
    end else if (pbStoreValid && state == ST_IDLE) begin
      targetAddr <= pbStoreAddr;
    end else if (doWrite && isReg(wAddrReg, `NCS_IDX_ADDR)) begin
      if (wStrbReg[0]) begin
        targetAddr[7:0] <= wDataReg[7:0];
      end
      if (wStrbReg[1]) begin
        targetAddr[15:8] <= wDataReg[15:8];
      end
    end
  end

  // ----------------------------------------
  // Unlock window
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unlockCnt <= 3'h0;
    end else if (keyWritten) begin
      unlockCnt <= `NCS_UNLOCK_INSTR;
    end else if (instrRetired && unlockCnt != 3'h0) begin
      unlockCnt <= unlockCnt - 3'h1;
    end
  end

  assign unlocked = unlockCnt != 3'h0;
  assign cmdTry = doWrite && isReg(wAddrReg, `NCS_IDX_CMD) && wStrbReg[0];
  assign reqCmd = ncs_cmd_t'(wDataReg[2:0]);
  assign toEe = targetAddr[`NCS_EE_SEL_BIT];
  // Fuse program from the CPU and erase of an untouched buffer never start
  assign startOk = reqCmd != CMD_NONE && !(reqCmd == CMD_FUSE_PROGRAM && !wFromDebug) &&
    !(reqCmd == CMD_PAGE_ERASE && pbMark == 32'h0000_0000);
  assign eeDone = state == ST_RUN && memDone && eeprom_active;
  assign pbClearNow = (state == ST_RUN && memDone) || (state == ST_CLEAR && clearCnt == 3'h0) ||
    wakeUp;

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  // Synchronous reset drops every phase: an ongoing operation is abandoned
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cmdReg <= CMD_NONE;
      flBusy <= 1'b0;
      eeprom_active <= 1'b0;
      faultReg <= 1'b0;
      cpuStall <= 1'b0;
      memStart <= 1'b0;
      memOp <= CMD_NONE;
      memTargetEeprom <= 1'b0;
      memWipeEeprom <= 1'b0;
      memAddr <= 16'h0000;
      memData <= '0;
      memByteMask <= 32'h0000_0000;
      clearCnt <= 3'h0;
    end else begin
      memStart <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Writes outside the window leave everything untouched
          if (cmdTry && unlocked && startOk) begin
            faultReg <= 1'b0;
            cmdReg <= reqCmd;
            memAddr <= targetAddr;
            memTargetEeprom <= toEe;
            memWipeEeprom <= 1'b0;
            for (int i = 0; i < `NCS_PAGE_BYTES; i++) begin
              memData[i*8 +: 8] <= pbuf[i];
            end
            case (reqCmd)
              CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_THEN_WRITE: begin
                memStart <= 1'b1;
                memOp <= (reqCmd == CMD_PAGE_WRITE) ? CMD_PAGE_WRITE : CMD_PAGE_ERASE;
                state <= (reqCmd == CMD_ERASE_THEN_WRITE) ? ST_CHAIN : ST_RUN;
                flBusy <= !toEe;
                eeprom_active <= toEe;
                cpuStall <= !toEe;
                memByteMask <= toEe ? pbMark : 32'hffff_ffff;
              end
              CMD_BUFFER_CLEAR: begin
                state <= ST_CLEAR;
                clearCnt <= `NCS_CLEAR_CYCLES - 3'h1;
                cpuStall <= 1'b1;
              end
              CMD_WHOLE_CHIP_WIPE: begin
                memStart <= 1'b1;
                memOp <= CMD_WHOLE_CHIP_WIPE;
                memWipeEeprom <= !keepEepromOnWipe;
                state <= ST_RUN;
                flBusy <= 1'b1;
                eeprom_active <= !keepEepromOnWipe;
                cpuStall <= 1'b1;
              end
              CMD_EEPROM_WIPE: begin
                memStart <= 1'b1;
                memOp <= CMD_EEPROM_WIPE;
                memWipeEeprom <= 1'b1;
                state <= ST_RUN;
                eeprom_active <= 1'b1;
                cpuStall <= 1'b1;
              end
              CMD_FUSE_PROGRAM: begin
                memStart <= 1'b1;
                memOp <= CMD_FUSE_PROGRAM;
                memData <= {240'h0, fuseDataReg};
                state <= ST_RUN;
                flBusy <= 1'b1;
              end
              default: begin
                state <= ST_IDLE;
              end
            endcase
          end else if (cmdTry && unlocked && reqCmd == CMD_FUSE_PROGRAM && !wFromDebug) begin
            faultReg <= 1'b1;
          end
        end
        ST_CHAIN: begin
          // Buffer is deliberately not cleared between phases
          if (memDone) begin
            memStart <= 1'b1;
            memOp <= CMD_PAGE_WRITE;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (memDone) begin
            state <= ST_IDLE;
            cmdReg <= CMD_NONE;
            flBusy <= 1'b0;
            eeprom_active <= 1'b0;
            cpuStall <= 1'b0;
          end
        end
        ST_CLEAR: begin
          if (clearCnt == 3'h0) begin
            state <= ST_IDLE;
            cmdReg <= CMD_NONE;
            cpuStall <= 1'b0;
          end else begin
            clearCnt <= clearCnt - 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // A command while busy is refused, and flagged only when written inside the window
      if (cmdTry && unlocked && state != ST_IDLE && reqCmd != CMD_NONE) begin
        faultReg <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Page buffer
  // ----------------------------------------
  assign pbIdx = pbStoreAddr[`NCS_PB_AW-1:0];

  always_ff @(posedge ref_clk) begin
    if (srst || pbClearNow) begin
      for (int i = 0; i < `NCS_PAGE_BYTES; i++) begin
        pbuf[i] <= 8'hff;
      end
      pbMark <= 32'h0000_0000;
    end else if (pbStoreValid && state == ST_IDLE) begin
      pbuf[pbIdx] <= pbuf[pbIdx] & pbStoreData;
      pbMark[pbIdx] <= 1'b1;
    end
  end

  // Helper for checking the AND store
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pbWrote <= 1'b0;
      pbIdxLast <= '0;
      pbExpect <= 8'hff;
    end else begin
      pbWrote <= pbStoreValid && state == ST_IDLE && !pbClearNow;
      pbIdxLast <= pbIdx;
      pbExpect <= pbuf[pbIdx] & pbStoreData;
    end
  end

  // ----------------------------------------
  // Ready flag, interrupt, sleep
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqFlagReg <= 1'b0;
    end else if (eeDone) begin
      irqFlagReg <= 1'b1;
    end else if (doWrite && isReg(wAddrReg, `NCS_IDX_FLAGS) && wStrbReg[0] &&
      wDataReg[`NCS_INT_BIT]) begin
      irqFlagReg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqReq <= 1'b0;
      wakeReq <= 1'b0;
      nvmAsleep <= 1'b0;
      clockHold <= 1'b0;
    end else begin
      irqReq <= irqFlagReg && intEnReg;
      wakeReq <= irqFlagReg && intEnReg && sleepActive && sleepIsIdle;
      nvmAsleep <= sleepActive && state == ST_IDLE;
      clockHold <= state != ST_IDLE;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_locked_ignore;
    @(posedge ref_clk) disable iff (srst)
    state == ST_IDLE && cmdTry && !unlocked |=> cmdReg == $past(cmdReg) && !memStart &&
      faultReg == $past(faultReg);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore) else $error("locked command acted");

  property p_clear_stall;
    @(posedge ref_clk) disable iff (srst)
    state == ST_IDLE && cmdTry && unlocked && reqCmd == CMD_BUFFER_CLEAR
    |=> cpuStall [*7] ##1 !cpuStall && pbMark == 32'h0000_0000;
  endproperty
  a_clear_stall: assert property (p_clear_stall) else $error("clear stall not seven");

  property p_irq_level;
    @(posedge ref_clk) disable iff (srst)
    irqFlagReg && intEnReg |=> irqReq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  property p_flag_w1c;
    @(posedge ref_clk) disable iff (srst)
    doWrite && isReg(wAddrReg, `NCS_IDX_FLAGS) && wStrbReg[0] && !eeDone
    |=> irqFlagReg == ($past(irqFlagReg) && !$past(wDataReg[0]));
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("flag write wrong");

  property p_pb_and;
    @(posedge ref_clk) disable iff (srst)
    pbWrote |-> pbuf[pbIdxLast] == pbExpect;
  endproperty
  a_pb_and: assert property (p_pb_and) else $error("buffer store not AND");

  property p_erase_empty;
    @(posedge ref_clk) disable iff (srst)
    state == ST_IDLE && cmdTry && unlocked && reqCmd == CMD_PAGE_ERASE && pbMark == 32'h0
    |=> state == ST_IDLE && !memStart;
  endproperty
  a_erase_empty: assert property (p_erase_empty) else $error("empty erase started");

  property p_fuse_cpu;
    @(posedge ref_clk) disable iff (srst)
    state == ST_IDLE && cmdTry && reqCmd == CMD_FUSE_PROGRAM && !wFromDebug |=> !memStart;
  endproperty
  a_fuse_cpu: assert property (p_fuse_cpu) else $error("cpu fuse program ran");

  property p_done_clear;
    @(posedge ref_clk) disable iff (srst)
    state == ST_RUN && memDone |=> pbMark == 32'h0 && !flBusy && !eeprom_active && !cpuStall;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("completion not cleaned");

  property p_busy_sleep;
    @(posedge ref_clk) disable iff (srst)
    sleepActive && state != ST_IDLE |=> clockHold && !nvmAsleep;
  endproperty
  a_busy_sleep: assert property (p_busy_sleep) else $error("slept while busy");

  property p_wake_idle;
    @(posedge ref_clk) disable iff (srst)
    !sleepIsIdle |=> !wakeReq;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("woke from deep sleep");

endmodule

// file: pkg/ncs_defines.svh
// Purpose: register map, field positions and counts of the sequencer
// Assumes: 32-bit AXI4-Lite words, byte address = 4 * index
// Notes: definitions only
`ifndef NCS_DEFINES_SVH
`define NCS_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define NCS_IDX_CMD 6'h00
`define NCS_IDX_LOCK 6'h01
`define NCS_IDX_STATUS 6'h02
`define NCS_IDX_IRQ_ENABLE_ALIAS 6'h03
`define NCS_IDX_FLAGS 6'h04
`define NCS_IDX_DATA 6'h06
`define NCS_IDX_ADDR 6'h08

// ----------------------------------------
// Fields
// ----------------------------------------
`define NCS_ST_FAULT 2
`define NCS_ST_EE 1
`define NCS_ST_FL 0
`define NCS_INT_BIT 0
`define NCS_EE_SEL_BIT 12

// ----------------------------------------
// Sizes, counts, answers
// ----------------------------------------
`define NCS_PAGE_BYTES 32
`define NCS_PB_AW 5
`define NCS_UNLOCK_INSTR 3'h4
`define NCS_CLEAR_CYCLES 3'h7
`define NCS_RESP_OKAY 2'h0
`define NCS_RESP_SLVERR 2'h2

`endif

// file: pkg/ncs_pkg.sv
// Purpose: types shared by the sequencer
// Assumes: nothing
// Notes: command codes match the command field encoding
package ncs_pkg;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_PAGE_WRITE = 3'b001,
    CMD_PAGE_ERASE = 3'b010,
    CMD_ERASE_THEN_WRITE = 3'b011,
    CMD_BUFFER_CLEAR = 3'b100,
    CMD_WHOLE_CHIP_WIPE = 3'b101,
    CMD_EEPROM_WIPE = 3'b110,
    CMD_FUSE_PROGRAM = 3'b111
  } ncs_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_CHAIN = 2'b10,
    ST_CLEAR = 2'b11
  } ncs_state_t;

endpackage

// file: dv/ncs_mem_model.sv
// Purpose: memory array side, ends each started phase after a delay
// Assumes: memStart is a one-cycle pulse
// Notes: delay is a parameter so slow and fast arrays can both be tried
`timescale 1ns/10ps
module ncs_mem_model #(parameter int LAT = 12) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic memStart,
  output logic memDone
);
  int cnt;
  always_ff @(posedge ref_clk) begin
    memDone <= 1'b0;
    if (srst) begin
      cnt <= 0; // Reset drops the phase
    end else if (memStart) begin
      cnt <= LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      memDone <= (cnt == 1);
    end
  end
endmodule

// file: dv/ncs_sequencer_tb.sv
// Purpose: register-level tests of the command sequencer
// Assumes: memory side answers through ncs_mem_model
// Notes: instructions retire only where the key window itself is under test
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module ncs_sequencer_tb;
  import ncs_pkg::*;
  logic ref_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, debugAccess, keyWritten, instrRetired, pbStoreValid;
  logic keepEepromOnWipe, sleepActive, sleepIsIdle, wakeUp, memDone, cpuStall;
  logic memStart, memTargetEeprom, memWipeEeprom, irqReq, wakeReq, nvmAsleep, clockHold;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pbStoreData;
  logic [31:0] s_axi_wdata, s_axi_rdata, memByteMask, v, mask;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] pbStoreAddr, memAddr;
  logic [255:0] memData, dat;
  ncs_cmd_t memOp, op;
  int error_cnt, check_count, starts, n, stallCnt, cyc;
  ncs_sequencer dut (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .debugAccess, .keyWritten, .instrRetired, .pbStoreValid,
    .pbStoreAddr, .pbStoreData, .keepEepromOnWipe, .sleepActive, .sleepIsIdle, .wakeUp,
    .memDone, .cpuStall, .memStart, .memOp, .memTargetEeprom, .memWipeEeprom, .memAddr,
    .memData, .memByteMask, .irqReq, .wakeReq, .nvmAsleep, .clockHold);
  ncs_mem_model #(.LAT(12)) mem (.ref_clk, .srst, .memStart, .memDone);
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cpuStall === 1'b1) stallCnt++;
    if (memStart === 1'b1) begin
      starts++;
      op = memOp;
      mask = memByteMask;
      dat = memData;
    end
    if (cyc > 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    // Ready stays high; lowering it would clash with the next call
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic pulse(input int which);
    if (which == 0) keyWritten <= 1;
    else if (which == 1) wakeUp <= 1;
    else instrRetired <= 1;
    @(posedge ref_clk);
    keyWritten <= 0;
    wakeUp <= 0;
    instrRetired <= 0;
    @(posedge ref_clk);
  endtask
  task automatic st(input logic [15:0] a, input logic [7:0] d);
    pbStoreAddr <= a;
    pbStoreData <= d;
    pbStoreValid <= 1;
    @(posedge ref_clk);
    pbStoreValid <= 0;
    @(posedge ref_clk);
  endtask
  task automatic cmd(input logic [31:0] c);
    pulse(0); // Key first, then command
    wr(8'h00, c);
    rd(8'h08);
  endtask
  task automatic idle();
    do rd(8'h08); while (v[1:0] !== 2'b00);
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {debugAccess, keyWritten, instrRetired, pbStoreValid, keepEepromOnWipe} = '0;
    {sleepActive, sleepIsIdle, wakeUp, s_axi_awaddr, s_axi_araddr, pbStoreData} = '0;
    {s_axi_wdata, pbStoreAddr} = '0;
    s_axi_wstrb = 4'hf;
    srst = 1;
    repeat (3) @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    rd(8'h08);
    `CHK(v, 32'h0)
    rd(8'h14);
    `CHK(r, 2'h2)
    wr(8'h14, 32'h1);
    `CHK(r, 2'h2)
    wr(8'h00, 32'h1);
    `CHK(r, 2'h0)
    rd(8'h00);
    `CHK(v, 32'h0)
    `CHK(starts, 0)
    st(16'h1003, 8'hf0);
    st(16'h1003, 8'h3c);
    cmd(32'h1);
    `CHK(v[1:0], 2'b10)
    `CHK(cpuStall, 1'b0)
    `CHK({mask, dat[31:16]}, 48'h8_30ff)
    `CHK(memTargetEeprom, 1'b1)
    idle();
    rd(8'h10);
    `CHK(v[0], 1'b1)
    `CHK(irqReq, 1'b0)
    wr(8'h0c, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK(irqReq, 1'b1)
    wr(8'h10, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(irqReq, 1'b1)
    wr(8'h10, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK(irqReq, 1'b0)
    // Flash page is erased before it is programmed
    st(16'h0005, 8'h5a);
    cmd(32'h2);
    `CHK({op, v[1:0], cpuStall, memAddr}, {CMD_PAGE_ERASE, 2'b01, 1'b1, 16'h0005})
    idle();
    st(16'h0005, 8'h5a);
    cmd(32'h1);
    `CHK(v[1:0], 2'b01)
    `CHK(cpuStall, 1'b1)
    `CHK({op, mask, dat[47:40]}, {CMD_PAGE_WRITE, 32'hffffffff, 8'h5a})
    cmd(32'h2);
    `CHK(v[2], 1'b1)
    idle();
    // Zero byte stored before wake must come back as ones
    st(16'h0002, 8'h00);
    pulse(1);
    st(16'h0007, 8'h11);
    n = starts;
    cmd(32'h3);
    `CHK(v[2:0], 3'b001)
    idle();
    `CHK(starts, n + 2)
    `CHK({op, dat[23:16], dat[63:56]}, {CMD_PAGE_WRITE, 8'hff, 8'h11})
    cmd(32'h2);
    `CHK(starts, n + 2)
    `CHK(v[2:0], 3'b000)
    // Window closes after four retired instructions
    stallCnt = 0;
    pulse(0);
    repeat (4) pulse(2);
    wr(8'h00, 32'h4);
    repeat (12) @(posedge ref_clk);
    `CHK(stallCnt, 0)
    pulse(0);
    repeat (3) pulse(2);
    wr(8'h00, 32'h4);
    repeat (12) @(posedge ref_clk);
    `CHK(stallCnt, 7)
    keepEepromOnWipe <= 1;
    sleepActive <= 1;
    cmd(32'h5);
    `CHK({op, v[2:0], memWipeEeprom}, {CMD_WHOLE_CHIP_WIPE, 4'b0010})
    `CHK({cpuStall, clockHold, nvmAsleep}, 3'b110)
    idle();
    `CHK({nvmAsleep, clockHold}, 2'b10)
    cmd(32'h6);
    `CHK({op, v[2:0], cpuStall, memWipeEeprom}, {CMD_EEPROM_WIPE, 5'b01011})
    idle();
    repeat (2) @(posedge ref_clk);
    `CHK({irqReq, wakeReq}, 2'b10)
    sleepIsIdle <= 1;
    repeat (2) @(posedge ref_clk);
    `CHK(wakeReq, 1'b1)
    wr(8'h10, 32'h1);
    sleepActive <= 0;
    sleepIsIdle <= 0;
    n = starts;
    cmd(32'h7);
    `CHK({v[2], starts}, {1'b1, n})
    debugAccess <= 1;
    wr(8'h20, 32'h0042);
    wr(8'h18, 32'hbeef);
    cmd(32'h7);
    `CHK({v[0], op, dat[15:0]}, {1'b1, CMD_FUSE_PROGRAM, 16'hbeef})
    `CHK(memAddr, 16'h0042)
    srst <= 1;
    @(posedge ref_clk);
    srst <= 0;
    @(posedge ref_clk);
    rd(8'h08);
    `CHK(v, 32'h0)
    `CHK({cpuStall, clockHold, memStart}, 3'b000)
    end_of_test();
  end
endmodule
